// ---- edpr_defines.vh ----
`ifndef EDPR_DEFINES_VH
`define EDPR_DEFINES_VH

// ----------------------------------------
// Aspect ratio codes, one per width
// ----------------------------------------
`define EDPR_W_X1 3'h0
`define EDPR_W_X2 3'h1
`define EDPR_W_X4 3'h2
`define EDPR_W_X9 3'h3
`define EDPR_W_X18 3'h4

// ----------------------------------------
// Block configurations
// ----------------------------------------
`define EDPR_MODE_DUAL 2'h0
`define EDPR_MODE_TWO 2'h1
`define EDPR_MODE_FIFO 2'h2

// ----------------------------------------
// Geometry
// ----------------------------------------
`define EDPR_ADDR_W 12
`define EDPR_DATA_W 18
`define EDPR_WORDS 512
`define EDPR_FIFO_SLOTS 13'h1000
`define EDPR_PORT_SYNC_W 39
`define EDPR_CFG_SYNC_W 28

// ----------------------------------------
// Timing
// ----------------------------------------
`define EDPR_PORT_FMAX_MHZ 250
`define EDPR_MCLK_MHZ 50

`endif

// ---- edpr_sync.v ----
`default_nettype none

module edpr_sync #(
   parameter WIDTH = 1
) (
   input wire mclk,
   input wire reset_n,
   input wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   assign syncOut = sync_q;

endmodule

`default_nettype wire

// ---- edpr_fifo_ctrl.v ----
`default_nettype none
`include "edpr_defines.vh"

module edpr_fifo_ctrl (
   input wire mclk,
   input wire reset_n,
   input wire fifoOn,
   input wire wrStep,
   input wire rdStep,
   input wire [2:0] wrWidth,
   input wire [2:0] rdWidth,
   input wire [12:0] almostFullLevel,
   input wire [12:0] almostEmptyLevel,
   output wire [11:0] wrAddr,
   output wire [11:0] rdAddr,
   output wire wrOk,
   output wire rdOk,
   output reg fullFlag_q,
   output reg emptyFlag_q,
   output reg almostFullFlag_q,
   output reg almostEmptyFlag_q
);

   // ----------------------------------------
   // Pointers count 1-bit slots so mixed widths share one scale
   // ----------------------------------------
   reg [12:0] wrPtr_q;
   reg [12:0] rdPtr_q;
   wire [12:0] wrSlots;
   wire [12:0] rdSlots;
   wire [12:0] level;
   wire fullNow;
   wire emptyNow;

   function [2:0] fnShift(input [2:0] w);
      case (w)
         `EDPR_W_X1: fnShift = 3'h0;
         `EDPR_W_X2: fnShift = 3'h1;
         `EDPR_W_X4: fnShift = 3'h2;
         `EDPR_W_X9: fnShift = 3'h3;
         default: fnShift = 3'h4;
      endcase
   endfunction

   assign wrSlots = 13'h0001 << fnShift(wrWidth);
   assign rdSlots = 13'h0001 << fnShift(rdWidth);
   assign level = wrPtr_q - rdPtr_q;
   assign fullNow = (level + wrSlots) > `EDPR_FIFO_SLOTS;
   assign emptyNow = level < rdSlots;
   assign wrOk = fifoOn & ~fullNow;
   assign rdOk = fifoOn & ~emptyNow;
   assign wrAddr = wrPtr_q[11:0] >> fnShift(wrWidth);
   assign rdAddr = rdPtr_q[11:0] >> fnShift(rdWidth);

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr_q <= 13'h0000;
         rdPtr_q <= 13'h0000;
         fullFlag_q <= 1'b0;
         emptyFlag_q <= 1'b1;
         almostFullFlag_q <= 1'b0;
         almostEmptyFlag_q <= 1'b1;
      end else if (!fifoOn) begin
         wrPtr_q <= 13'h0000;
         rdPtr_q <= 13'h0000;
         fullFlag_q <= 1'b0;
         emptyFlag_q <= 1'b1;
         almostFullFlag_q <= 1'b0;
         almostEmptyFlag_q <= 1'b1;
      end else begin
         if (wrStep && wrOk) begin
            wrPtr_q <= wrPtr_q + wrSlots;
         end
         if (rdStep && rdOk) begin
            rdPtr_q <= rdPtr_q + rdSlots;
         end
         fullFlag_q <= fullNow;
         emptyFlag_q <= emptyNow;
         almostFullFlag_q <= level >= almostFullLevel;
         almostEmptyFlag_q <= level <= almostEmptyLevel;
      end
   end

endmodule

`default_nettype wire

// ---- edpr_top.v ----
`default_nettype none
`include "edpr_defines.vh"

module edpr_top (
   input wire mclk,
   input wire reset_n,
   input wire [1:0] memMode,
   input wire portAClk,
   input wire portAClkInv,
   input wire portAEnable_n,
   input wire portAWrite,
   input wire [11:0] portAAddr,
   input wire [17:0] portAWrData,
   input wire [2:0] portAWidthSelect,
   input wire portAPipelined,
   input wire portAPassThru,
   output reg [17:0] portARdData_q,
   input wire portBClk,
   input wire portBClkInv,
   input wire portBEnable_n,
   input wire portBWrite,
   input wire [11:0] portBAddr,
   input wire [17:0] portBWrData,
   input wire [2:0] portBWidthSelect,
   input wire portBPipelined,
   input wire portBPassThru,
   output reg [17:0] portBRdData_q,
   input wire [12:0] fifoAlmostFullLevel,
   input wire [12:0] fifoAlmostEmptyLevel,
   output wire fifoFullFlag,
   output wire fifoEmptyFlag,
   output wire fifoAlmostFullFlag,
   output wire fifoAlmostEmptyFlag
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Port clocks are sampled on mclk, so each must stay below mclk/4
   // here; the 250 MHz figure is for a hard macro, not this model.
   wire [38:0] portASync;
   wire [38:0] portBSync;
   wire [27:0] cfgSync;

   edpr_sync #(.WIDTH(`EDPR_PORT_SYNC_W)) syncPortA (
      .mclk(mclk),
      .reset_n(reset_n),
      .asyncIn({portAClk, portAEnable_n, portAWrite, portAAddr,
         portAWrData, portAWidthSelect, portAClkInv, portAPipelined,
         portAPassThru}),
      .syncOut(portASync)
   );

   edpr_sync #(.WIDTH(`EDPR_PORT_SYNC_W)) syncPortB (
      .mclk(mclk),
      .reset_n(reset_n),
      .asyncIn({portBClk, portBEnable_n, portBWrite, portBAddr,
         portBWrData, portBWidthSelect, portBClkInv, portBPipelined,
         portBPassThru}),
      .syncOut(portBSync)
   );

   edpr_sync #(.WIDTH(`EDPR_CFG_SYNC_W)) syncCfg (
      .mclk(mclk),
      .reset_n(reset_n),
      .asyncIn({memMode, fifoAlmostFullLevel, fifoAlmostEmptyLevel}),
      .syncOut(cfgSync)
   );

   wire aClk = portASync[38];
   wire aEn_n = portASync[37];
   wire aWr = portASync[36];
   wire [11:0] aAddrUser = portASync[35:24];
   wire [17:0] aData = portASync[23:6];
   wire [2:0] aWidth = portASync[5:3];
   wire aInv = portASync[2];
   wire aPipe = portASync[1];
   wire aPass = portASync[0];
   wire bClk = portBSync[38];
   wire bEn_n = portBSync[37];
   wire bWr = portBSync[36];
   wire [11:0] bAddrUser = portBSync[35:24];
   wire [17:0] bData = portBSync[23:6];
   wire [2:0] bWidth = portBSync[5:3];
   wire bInv = portBSync[2];
   wire bPipe = portBSync[1];
   wire bPass = portBSync[0];
   wire [1:0] mode = cfgSync[27:26];
   wire [12:0] aFullLvl = cfgSync[25:13];
   wire [12:0] aEmptyLvl = cfgSync[12:0];

   // ----------------------------------------
   // Width helpers
   // ----------------------------------------
   function [8:0] fnIdx(input [11:0] a, input [2:0] w);
      case (w)
         `EDPR_W_X1: fnIdx = a[11:3];
         `EDPR_W_X2: fnIdx = a[10:2];
         `EDPR_W_X4: fnIdx = a[9:1];
         `EDPR_W_X9: fnIdx = a[8:0];
         default: fnIdx = {a[7:0], 1'b0};
      endcase
   endfunction

   // Little-endian sub-word position within a 9-bit word
   function [3:0] fnPos(input [11:0] a, input [2:0] w);
      case (w)
         `EDPR_W_X1: fnPos = {1'b0, a[2:0]};
         `EDPR_W_X2: fnPos = {1'b0, a[1:0], 1'b0};
         `EDPR_W_X4: fnPos = {a[0], 3'h0} >> 1;
         default: fnPos = 4'h0;
      endcase
   endfunction

   function [8:0] fnMask(input [2:0] w);
      case (w)
         `EDPR_W_X1: fnMask = 9'h001;
         `EDPR_W_X2: fnMask = 9'h003;
         `EDPR_W_X4: fnMask = 9'h00f;
         default: fnMask = 9'h1ff;
      endcase
   endfunction

   function [17:0] fnTrim(input [17:0] d, input [2:0] w);
      case (w)
         `EDPR_W_X1: fnTrim = {17'h00000, d[0]};
         `EDPR_W_X2: fnTrim = {16'h0000, d[1:0]};
         `EDPR_W_X4: fnTrim = {14'h0000, d[3:0]};
         `EDPR_W_X9: fnTrim = {9'h000, d[8:0]};
         default: fnTrim = d;
      endcase
   endfunction

   function [8:0] fnMerge(input [8:0] old, input [17:0] d,
         input [2:0] w, input [3:0] pos);
      reg [8:0] m;
      begin
         m = fnMask(w) << pos;
         fnMerge = (old & ~m) | ((d[8:0] << pos) & m);
      end
   endfunction

   function [17:0] fnRead(input [8:0] lo, input [8:0] hi,
         input [2:0] w, input [3:0] pos);
      reg [8:0] s;
      begin
         s = lo >> pos;
         if (w == `EDPR_W_X18) begin
            fnRead = {hi, lo};
         end else begin
            fnRead = fnTrim({9'h000, s}, w);
         end
      end
   endfunction

   // ----------------------------------------
   // Port clock edges and access decode
   // ----------------------------------------
   reg aClkPrev_q;
   reg bClkPrev_q;

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         aClkPrev_q <= 1'b0;
         bClkPrev_q <= 1'b0;
      end else begin
         aClkPrev_q <= aClk;
         bClkPrev_q <= bClk;
      end
   end

   wire aEdge = aInv ? (aClkPrev_q & ~aClk) : (~aClkPrev_q & aClk);
   wire bEdge = bInv ? (bClkPrev_q & ~bClk) : (~bClkPrev_q & bClk);
   wire aAcc = aEdge & ~aEn_n;
   wire bAcc = bEdge & ~bEn_n;
   wire isDual = mode == `EDPR_MODE_DUAL;
   wire isFifo = mode == `EDPR_MODE_FIFO;
   wire fifoWrOk;
   wire fifoRdOk;
   wire [11:0] fifoWrAddr;
   wire [11:0] fifoRdAddr;

   // Dual: each port free; two-port and FIFO: A writes, B reads
   wire aWrite = aAcc & (isDual ? aWr : (~isFifo | fifoWrOk));
   wire aRead = aAcc & isDual & ~aWr;
   wire bWrite = bAcc & isDual & bWr;
   wire bRead = bAcc & (isDual ? ~bWr : (~isFifo | fifoRdOk));

   wire [11:0] aAddr = isFifo ? fifoWrAddr : aAddrUser;
   wire [11:0] bAddr = isFifo ? fifoRdAddr : bAddrUser;

   // ----------------------------------------
   // FIFO controller
   // ----------------------------------------
   edpr_fifo_ctrl fifoCtrl (
      .mclk(mclk),
      .reset_n(reset_n),
      .fifoOn(isFifo),
      .wrStep(aAcc),
      .rdStep(bAcc),
      .wrWidth(aWidth),
      .rdWidth(bWidth),
      .almostFullLevel(aFullLvl),
      .almostEmptyLevel(aEmptyLvl),
      .wrAddr(fifoWrAddr),
      .rdAddr(fifoRdAddr),
      .wrOk(fifoWrOk),
      .rdOk(fifoRdOk),
      .fullFlag_q(fifoFullFlag),
      .emptyFlag_q(fifoEmptyFlag),
      .almostFullFlag_q(fifoAlmostFullFlag),
      .almostEmptyFlag_q(fifoAlmostEmptyFlag)
   );

   // ----------------------------------------
   // Array: 512 words of 9 bits
   // ----------------------------------------
   reg [8:0] mem [0:`EDPR_WORDS-1];
   wire [8:0] aIdx = fnIdx(aAddr, aWidth);
   wire [8:0] bIdx = fnIdx(bAddr, bWidth);
   wire [3:0] aPos = fnPos(aAddr, aWidth);
   wire [3:0] bPos = fnPos(bAddr, bWidth);
   wire [8:0] aLoWord = mem[aIdx];
   wire [8:0] aHiWord = mem[aIdx | 9'h001];
   wire [8:0] bLoWord = mem[bIdx];
   wire [8:0] bHiWord = mem[bIdx | 9'h001];

   // Port B is applied last, so it wins a same-word write collision;
   // reads in that cycle see the old contents.
   always @(posedge mclk) begin
      if (aWrite) begin
         mem[aIdx] <= fnMerge(aLoWord, aData, aWidth, aPos);
         if (aWidth == `EDPR_W_X18) begin
            mem[aIdx | 9'h001] <= aData[17:9];
         end
      end
      if (bWrite) begin
         mem[bIdx] <= fnMerge(bLoWord, bData, bWidth, bPos);
         if (bWidth == `EDPR_W_X18) begin
            mem[bIdx | 9'h001] <= bData[17:9];
         end
      end
   end

   // ----------------------------------------
   // Read outputs
   // ----------------------------------------
   reg [17:0] aStage_q;
   reg [17:0] bStage_q;
   wire aLoad = aRead | (aWrite & aPass);
   wire bLoad = bRead | (bWrite & bPass);
   wire [17:0] aNew = aRead ? fnRead(aLoWord, aHiWord, aWidth, aPos)
      : fnTrim(aData, aWidth);
   wire [17:0] bNew = bRead ? fnRead(bLoWord, bHiWord, bWidth, bPos)
      : fnTrim(bData, bWidth);

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         aStage_q <= 18'h00000;
         portARdData_q <= 18'h00000;
      end else if (aAcc) begin
         if (aPipe) begin
            portARdData_q <= aStage_q;
            if (aLoad) begin
               aStage_q <= aNew;
            end
         end else if (aLoad) begin
            portARdData_q <= aNew;
         end
      end
   end

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         bStage_q <= 18'h00000;
         portBRdData_q <= 18'h00000;
      end else if (bAcc) begin
         if (bPipe) begin
            portBRdData_q <= bStage_q;
            if (bLoad) begin
               bStage_q <= bNew;
            end
         end else if (bLoad) begin
            portBRdData_q <= bNew;
         end
      end
   end

endmodule

`default_nettype wire

// ---- edpr_top_monitor.sv ----
`default_nettype none
`include "edpr_defines.vh"
module edpr_top_monitor (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [1:0] memMode,
   input wire logic portAClk,
   input wire logic portAClkInv,
   input wire logic portAEnable_n,
   input wire logic portAWrite,
   input wire logic portAPipelined,
   input wire logic portAPassThru,
   input wire logic [17:0] portARdData_q,
   input wire logic portBClk,
   input wire logic portBClkInv,
   input wire logic portBEnable_n,
   input wire logic portBWrite,
   input wire logic portBPipelined,
   input wire logic portBPassThru,
   input wire logic [17:0] portBRdData_q,
   input wire logic fifoFullFlag,
   input wire logic fifoEmptyFlag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic aClk_q, bClk_q, aEdge, bEdge, dual, fifo;
   logic [7:0] aEnH_q, bEnH_q, aLdH_q, bLdH_q;
   assign dual = memMode == `EDPR_MODE_DUAL;
   assign fifo = memMode == `EDPR_MODE_FIFO;
   assign aEdge = portAClk != aClk_q && portAClk != portAClkInv
      && !portAEnable_n;
   assign bEdge = portBClk != bClk_q && portBClk != portBClkInv
      && !portBEnable_n;
   // ----------------------------------------
   // Recent enabled port edges
   // ----------------------------------------
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         aClk_q <= 1'b0;
         bClk_q <= 1'b0;
         aEnH_q <= 8'h0;
         bEnH_q <= 8'h0;
         aLdH_q <= 8'h0;
         bLdH_q <= 8'h0;
      end else begin
         aClk_q <= portAClk;
         bClk_q <= portBClk;
         aEnH_q <= {aEnH_q[6:0], aEdge};
         bEnH_q <= {bEnH_q[6:0], bEdge};
         aLdH_q <= {aLdH_q[6:0], aEdge && (portAPipelined
            || portAPassThru || (dual && !portAWrite))};
         bLdH_q <= {bLdH_q[6:0], bEdge && (portBPipelined
            || portBPassThru || !(dual && portBWrite))};
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_reset_state: assert property ($rose(reset_n) |->
      portARdData_q == 18'h0 && portBRdData_q == 18'h0
      && fifoEmptyFlag && !fifoFullFlag) else $error("bad reset state");
   a_out_a_cause: assert property ($changed(portARdData_q)
      |-> |aLdH_q) else $error("port A output moved without access");
   a_out_b_cause: assert property ($changed(portBRdData_q)
      |-> |bLdH_q) else $error("port B output moved without access");
   a_flags_excl: assert property (!(fifoFullFlag && fifoEmptyFlag))
      else $error("full and empty together");
   a_idle_flags: assert property ((!fifo)[*6] |->
      fifoEmptyFlag && !fifoFullFlag) else $error("flags outside fifo");
   a_empty_fall: assert property ($fell(fifoEmptyFlag) |->
      fifo && |aEnH_q) else $error("empty fell without write");
   a_empty_rise: assert property ($rose(fifoEmptyFlag) |->
      !fifo || |bEnH_q) else $error("empty rose without read");
   a_full_rise: assert property ($rose(fifoFullFlag) |->
      |aEnH_q) else $error("full rose without write");
endmodule
bind edpr_top edpr_top_monitor i_mon (.mclk, .reset_n, .memMode,
   .portAClk, .portAClkInv, .portAEnable_n, .portAWrite, .portAPipelined,
   .portAPassThru, .portARdData_q, .portBClk, .portBClkInv, .portBEnable_n,
   .portBWrite, .portBPipelined, .portBPassThru, .portBRdData_q,
   .fifoFullFlag, .fifoEmptyFlag);
`default_nettype wire

// ---- edpr_port_model.sv ----
`default_nettype none
module edpr_port_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic go,
   input wire logic inv,
   output logic pClk,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_q;
   // Setup 3, active 4, recovery 5: the block samples through two flops
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= 4'h0;
      end else if (cnt_q == 4'hc) begin
         cnt_q <= 4'h0;
      end else if (cnt_q != 4'h0 || go) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   // Clock rests at its idle level between accesses
   assign pClk = inv ^ (cnt_q >= 4'h4 && cnt_q < 4'h8);
   assign busy = cnt_q != 4'h0;
endmodule
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
`include "edpr_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset_n, aGo, bGo, aBusy, bBusy, portAClk, portBClk;
   logic [1:0] memMode;
   logic portAClkInv, portAEnable_n, portAWrite, portAPipelined;
   logic portAPassThru, portBClkInv, portBEnable_n, portBWrite;
   logic portBPipelined, portBPassThru;
   logic [11:0] portAAddr, portBAddr;
   logic [17:0] portAWrData, portBWrData, portARdData_q, portBRdData_q;
   logic [2:0] portAWidthSelect, portBWidthSelect;
   logic [12:0] fifoAlmostFullLevel, fifoAlmostEmptyLevel;
   logic fifoFullFlag, fifoEmptyFlag, fifoAlmostFullFlag;
   logic fifoAlmostEmptyFlag;
   int n_fail, checked, cyc;
   logic [32:0] wTbl [9] = '{{`EDPR_W_X9, 12'h6, 18'h1c3},
      {`EDPR_W_X9, 12'h7, 18'h152}, {`EDPR_W_X4, 12'hc, 18'h3},
      {`EDPR_W_X4, 12'hd, 18'hc}, {`EDPR_W_X4, 12'he, 18'h2},
      {`EDPR_W_X2, 12'h1b, 18'h3}, {`EDPR_W_X1, 12'h30, 18'h1},
      {`EDPR_W_X1, 12'h32, 18'h0}, {`EDPR_W_X18, 12'h3, 18'h2a5c3}};
   edpr_top i_dut (.mclk, .reset_n, .memMode, .portAClk, .portAClkInv,
      .portAEnable_n, .portAWrite, .portAAddr, .portAWrData,
      .portAWidthSelect, .portAPipelined, .portAPassThru, .portARdData_q,
      .portBClk, .portBClkInv, .portBEnable_n, .portBWrite, .portBAddr,
      .portBWrData, .portBWidthSelect, .portBPipelined, .portBPassThru,
      .portBRdData_q, .fifoAlmostFullLevel, .fifoAlmostEmptyLevel,
      .fifoFullFlag, .fifoEmptyFlag, .fifoAlmostFullFlag,
      .fifoAlmostEmptyFlag);
   edpr_port_model i_portA (.mclk, .reset_n, .go(aGo),
      .inv(portAClkInv), .pClk(portAClk), .busy(aBusy));
   edpr_port_model i_portB (.mclk, .reset_n, .go(bGo),
      .inv(portBClkInv), .pClk(portBClk), .busy(bBusy));
   always #10 mclk = ~mclk;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task results();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
   task cmp(input logic [17:0] g, input logic [17:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Request and qualifiers held until the port clock has come back
   task acc(input bit p, input logic en, input logic wr,
      input logic [11:0] ad, input logic [17:0] d);
      @(posedge mclk);
      if (p) begin
         portBEnable_n <= en;
         portBWrite <= wr;
         portBAddr <= ad;
         portBWrData <= d;
         bGo <= 1'b1;
      end else begin
         portAEnable_n <= en;
         portAWrite <= wr;
         portAAddr <= ad;
         portAWrData <= d;
         aGo <= 1'b1;
      end
      @(posedge mclk);
      aGo <= 1'b0;
      bGo <= 1'b0;
      repeat (20) begin
         @(posedge mclk);
         #1;
         if (!aBusy && !bBusy) break;
      end
      repeat (4) @(posedge mclk);
   endtask
   task wsel(input logic [1:0] m, input logic [2:0] wa, input logic [2:0] wb);
      @(posedge mclk);
      memMode <= m;
      portAWidthSelect <= wa;
      portBWidthSelect <= wb;
      repeat (8) @(posedge mclk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset();
      cmp(portARdData_q, 18'h0);
      cmp({fifoEmptyFlag, fifoAlmostEmptyFlag}, 18'h3);
      cmp({fifoFullFlag, fifoAlmostFullFlag}, 18'h0);
      $display("t_reset done");
   endtask
   task t_dual();
      wsel(`EDPR_MODE_DUAL, `EDPR_W_X9, `EDPR_W_X9);
      acc(0, 0, 1, 12'h5, 18'h1ab);
      cmp(portARdData_q, 18'h0);
      acc(1, 0, 0, 12'h5, 18'h0);
      cmp(portBRdData_q, 18'h1ab);
      acc(0, 1, 0, 12'h5, 18'h0);
      cmp(portARdData_q, 18'h0);
      portAPassThru <= 1'b1;
      acc(0, 0, 1, 12'h6, 18'h0c3);
      cmp(portARdData_q, 18'h0c3);
      portAPassThru <= 1'b0;
      $display("t_dual done");
   endtask
   task t_widths();
      wsel(`EDPR_MODE_DUAL, `EDPR_W_X18, `EDPR_W_X9);
      acc(0, 0, 1, 12'h3, 18'h2a5c3);
      for (int i = 0; i < 9; i++) begin
         wsel(`EDPR_MODE_DUAL, `EDPR_W_X18, wTbl[i][32:30]);
         acc(1, 0, 0, wTbl[i][29:18], 18'h0);
         cmp(portBRdData_q, wTbl[i][17:0]);
      end
      wsel(`EDPR_MODE_DUAL, `EDPR_W_X4, `EDPR_W_X9);
      acc(0, 0, 1, 12'h10, 18'h5);
      acc(0, 0, 1, 12'h11, 18'ha);
      acc(1, 0, 0, 12'h8, 18'h0);
      cmp(portBRdData_q & 18'hff, 18'ha5);
      $display("t_widths done");
   endtask
   task t_pipe_inv();
      wsel(`EDPR_MODE_DUAL, `EDPR_W_X9, `EDPR_W_X9);
      portBPipelined <= 1'b1;
      acc(1, 0, 0, 12'h5, 18'h0);
      acc(1, 0, 0, 12'h6, 18'h0);
      cmp(portBRdData_q, 18'h1ab);
      acc(1, 0, 0, 12'h6, 18'h0);
      cmp(portBRdData_q, 18'h1c3);
      portBPipelined <= 1'b0;
      portBClkInv <= 1'b1;
      repeat (6) @(posedge mclk);
      acc(1, 0, 0, 12'h5, 18'h0);
      cmp(portBRdData_q, 18'h1ab);
      portBClkInv <= 1'b0;
      repeat (6) @(posedge mclk);
      $display("t_pipe_inv done");
   endtask
   task t_two();
      wsel(`EDPR_MODE_TWO, `EDPR_W_X9, `EDPR_W_X9);
      acc(0, 0, 0, 12'h9, 18'h155);
      acc(1, 0, 1, 12'h9, 18'h0);
      cmp(portBRdData_q, 18'h155);
      $display("t_two done");
   endtask
   task t_fifo();
      wsel(`EDPR_MODE_FIFO, `EDPR_W_X18, `EDPR_W_X18);
      cmp(fifoEmptyFlag, 18'h1);
      for (int i = 1; i <= 256; i++) begin
         acc(0, 0, 0, 12'hfff, 18'(i));
         if (i == 1) cmp(fifoEmptyFlag, 18'h0);
         if (i == 127) cmp(fifoAlmostFullFlag, 18'h0);
         if (i == 128) cmp(fifoAlmostFullFlag, 18'h1);
      end
      cmp(fifoFullFlag, 18'h1);
      acc(0, 0, 0, 12'h0, 18'h3ffff);
      for (int i = 1; i <= 256; i++) begin
         acc(1, 0, 0, 12'h0, 18'h0);
         if (i == 1) cmp(portBRdData_q, 18'h1);
      end
      cmp({fifoEmptyFlag, portBRdData_q[16:0]}, 18'h20100);
      acc(1, 0, 0, 12'h0, 18'h0);
      cmp(portBRdData_q, 18'h100);
      $display("t_fifo done");
   endtask
   task t_pair();
      wsel(`EDPR_MODE_DUAL, `EDPR_W_X9, `EDPR_W_X9);
      // One clock source, port B inverted: both ports act on one edge
      portBClkInv <= 1'b1;
      {portAEnable_n, portAWrite, portAAddr, portAWrData} <=
         {2'h1, 12'h20, 18'h0a5};
      {portBEnable_n, portBWrite, portBAddr} <= {2'h0, 12'h5};
      repeat (6) @(posedge mclk);
      aGo <= 1'b1;
      bGo <= 1'b1;
      @(posedge mclk);
      aGo <= 1'b0;
      bGo <= 1'b0;
      repeat (20) @(posedge mclk);
      cmp(portBRdData_q, 18'h1ab);
      acc(1, 0, 0, 12'h20, 18'h0);
      cmp(portBRdData_q, 18'h0a5);
      portBClkInv <= 1'b0;
      repeat (6) @(posedge mclk);
      $display("t_pair done");
   endtask
   task t_single();
      // Port B grounded: no clock edge, so it never accesses
      wsel(`EDPR_MODE_DUAL, `EDPR_W_X9, `EDPR_W_X1);
      {portBEnable_n, portBWrite, portBAddr, portBWrData} <= 32'h0;
      acc(0, 0, 1, 12'h21, 18'h13c);
      acc(0, 0, 0, 12'h21, 18'h0);
      cmp(portARdData_q, 18'h13c);
      cmp(portBRdData_q, 18'h0a5);
      $display("t_single done");
   endtask
   task t_async();
      @(posedge mclk);
      reset_n <= 1'b0;
      #2;
      cmp(portBRdData_q, 18'h0);
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      $display("t_async done");
   endtask
   initial begin
      {reset_n, aGo, bGo, portAClkInv, portBClkInv} = 5'h0;
      {portAPipelined, portBPipelined, portAPassThru} = 3'h0;
      {portBPassThru, portAWrite, portBWrite, cyc} = 0;
      {portAEnable_n, portBEnable_n} = 2'h3;
      {portAAddr, portBAddr, portAWrData, portBWrData} = 0;
      memMode = `EDPR_MODE_DUAL;
      portAWidthSelect = `EDPR_W_X9;
      portBWidthSelect = `EDPR_W_X9;
      fifoAlmostFullLevel = 13'h800;
      fifoAlmostEmptyLevel = 13'h10;
      n_fail = 0;
      checked = 0;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reset();
      t_dual();
      t_widths();
      t_pipe_inv();
      t_two();
      t_pair();
      t_single();
      t_fifo();
      t_async();
      results();
   end
endmodule
`default_nettype wire
